// ==== verilog/mode_reset_pkg.sv ====
package mode_reset_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] STOP_ENTRY_TRIGGER_ADDR  = 12'hC02;
    localparam logic [11:0] OPERATING_MODE_REG0_ADDR = 12'hC00;
    localparam logic [11:0] IRQ_FLAG_ADDR            = 12'hC04;
    localparam logic [11:0] IRQ_ENABLE_ADDR          = 12'hC05;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int RUN_REQUEST_BIT     = 0;
    localparam int LOW_POWER_CLOCK_BIT = 1;
    localparam int SOFT_RESET_BIT      = 3;
    localparam int SUPPLY_FAIL_BIT     = 0;
    localparam int SUPPLY_FAIL_EN_BIT  = 0;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] OPERATING_MODE_REG0_RESET = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_RESET          = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS        = 20;
    localparam int EXT_FILTER_CYCLES    = 4;
    localparam int RESUME_CYCLES        = 4;
    localparam int STOP_WAKE_NS         = 128000;
    localparam int STOP_WAKE_CYCLES     = STOP_WAKE_NS / CLK_PERIOD_NS;
    localparam int WATCHDOG_PULSE_CYCLES = 4;
    localparam int WATCHDOG_TIMEOUT     = 100000;

    // ------------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_INIT    = 3'b000,
        ST_RUN     = 3'b001,
        ST_STOP    = 3'b011,
        ST_RESET   = 3'b010,
        ST_RELEASE = 3'b110
    } mode_t;

endpackage : mode_reset_pkg

// ==== verilog/mode_reset_sequencer.sv ====
`timescale 1ns/1ps
module mode_reset_sequencer #(
    parameter int STOP_WAKE = mode_reset_pkg::STOP_WAKE_CYCLES,
    parameter int WD_TIMEOUT = mode_reset_pkg::WATCHDOG_TIMEOUT
) (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Link clock and requests from the serial slave port
    input  wire logic        linkClk,
    input  wire logic        reqValid,
    input  wire logic        reqWrite,
    input  wire logic [11:0] reqAddr,
    input  wire logic [7:0]  reqData,
    output logic             reqReady,
    output logic             rspValid,
    output logic [7:0]       rspData,
    // Pins
    input  wire logic        sselN,
    input  wire logic        resetPinIn,
    output logic             resetPinOut,
    output logic             resetPinOe,
    output logic             irqN,
    // Supply comparators and watchdog service
    input  wire logic        supplyAboveResetTrip,
    input  wire logic        supplyAbovePowerOnTrip,
    input  wire logic        supplyBelowWarnLevel,
    input  wire logic        watchdogKick,
    // Mode status
    output logic             modeInit,
    output logic             modeRun,
    output logic             modeStop,
    output logic             processingEnable,
    output logic             lowPowerClockSelect
);
    import mode_reset_pkg::*;

    // ------------------------------------------------------------------
    // Reset synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rstPipe;
    logic [1:0] linkRstPipe;
    logic       rstN;
    logic       linkRstN;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end

    always_ff @(posedge linkClk or negedge resetn) begin
        if (!resetn) begin
            linkRstPipe <= 2'h0;
        end else begin
            linkRstPipe <= {linkRstPipe[0], 1'b1};
        end
    end

    assign rstN     = rstPipe[1];
    assign linkRstN = linkRstPipe[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        mode_t       mode;
        logic [1:0]  sselPipe;
        logic [1:0]  pinPipe;
        logic [1:0]  porPipe;
        logic [1:0]  porLowPipe;
        logic [1:0]  warnPipe;
        logic [1:0]  reqPipe;
        logic        reqSeen;
        logic [2:0]  lowCnt;
        logic [15:0] holdCnt;
        logic [15:0] relCnt;
        logic [23:0] wdCnt;
        logic        pinDrive;
        logic        stopArmed;
        logic [7:0]  opMode;
        logic        supplyFail;
        logic [7:0]  irqEnable;
        logic [7:0]  rdData;
        logic        irqN;
    } core_t;

    typedef struct packed {
        logic        reqTog;
        logic [1:0]  ackPipe;
        logic        ackLast;
        logic        write;
        logic [11:0] addr;
        logic [7:0]  data;
        logic        rspValid;
        logic [7:0]  rspData;
    } link_t;

    localparam core_t CORE_RESET = '{
        mode: ST_RESET, sselPipe: 2'h3, pinPipe: 2'h3, porPipe: 2'h0,
        porLowPipe: 2'h0, warnPipe: 2'h0, reqPipe: 2'h0, reqSeen: 1'b0,
        lowCnt: 3'h0, holdCnt: 16'h0000, relCnt: 16'h0000, wdCnt: 24'h000000,
        pinDrive: 1'b1, stopArmed: 1'b0, opMode: OPERATING_MODE_REG0_RESET,
        supplyFail: 1'b0, irqEnable: IRQ_ENABLE_RESET, rdData: 8'h00, irqN: 1'b1
    };

    localparam link_t LINK_RESET = '{
        reqTog: 1'b0, ackPipe: 2'h0, ackLast: 1'b0, write: 1'b0, addr: 12'h000, data: 8'h00,
        rspValid: 1'b0, rspData: 8'h00
    };

    localparam logic [2:0]  FILTER_LAST = 3'(EXT_FILTER_CYCLES);
    localparam logic [15:0] RESUME_LAST = 16'(RESUME_CYCLES - 1);
    localparam logic [15:0] WAKE_LAST   = 16'(STOP_WAKE - 1);
    localparam logic [15:0] PULSE_LAST  = 16'(WATCHDOG_PULSE_CYCLES - 1);
    localparam logic [23:0] WD_LAST     = 24'(WD_TIMEOUT - 1);

    core_t q;
    core_t d;
    link_t lq;
    link_t ld;

    // ------------------------------------------------------------------
    // Link domain: hold one request until the core acknowledges it
    // ------------------------------------------------------------------
    logic linkIdle;

    always_comb begin
        linkIdle      = (lq.ackPipe[1] == lq.reqTog);
        ld            = lq;
        ld.ackPipe    = {lq.ackPipe[0], q.reqSeen};
        ld.ackLast    = lq.ackPipe[1];
        ld.rspValid   = 1'b0;
        if (linkIdle && reqValid) begin
            ld.reqTog = ~lq.reqTog;
            ld.write  = reqWrite;
            ld.addr   = reqAddr;
            ld.data   = reqData;
        end
        // Answer follows the settled acknowledge; read data is stable by then
        if (lq.ackPipe[1] != lq.ackLast && lq.ackPipe[1] == lq.reqTog) begin
            ld.rspValid = 1'b1;
            ld.rspData  = q.rdData;
        end
    end

    always_ff @(posedge linkClk or negedge linkRstN) begin
        if (!linkRstN) begin
            lq <= LINK_RESET;
        end else begin
            lq <= ld;
        end
    end

    assign reqReady = linkIdle;
    assign rspValid = lq.rspValid;
    assign rspData  = lq.rspData;

    // ------------------------------------------------------------------
    // Core domain: modes, reset sources, registers
    // ------------------------------------------------------------------
    logic inStop;
    logic extLow;
    logic extActive;
    logic porFail;
    logic wdExpire;
    logic newReq;
    logic clearRegs;

    always_comb begin
        d            = q;
        d.sselPipe   = {q.sselPipe[0], sselN};
        d.pinPipe    = {q.pinPipe[0], resetPinIn};
        d.porPipe    = {q.porPipe[0], supplyAboveResetTrip};
        d.porLowPipe = {q.porLowPipe[0], supplyAbovePowerOnTrip};
        d.warnPipe   = {q.warnPipe[0], supplyBelowWarnLevel};
        d.reqPipe    = {q.reqPipe[0], lq.reqTog};
        inStop       = (q.mode == ST_STOP);
        clearRegs    = 1'b0;
        newReq       = (q.reqPipe[1] != q.reqSeen);
        d.reqSeen    = q.reqPipe[1];

        // Synchronous filter; own drive is not mistaken for an outside reset
        extLow = !q.pinPipe[1] && !q.pinDrive;
        if (extLow) begin
            if (q.lowCnt != FILTER_LAST) begin
                d.lowCnt = q.lowCnt + 3'h1;
            end
        end else begin
            d.lowCnt = 3'h0;
        end
        extActive = (q.lowCnt == FILTER_LAST);

        // Brownout disabled in Stop: only the lower threshold counts
        porFail  = inStop ? !q.porLowPipe[1] : !q.porPipe[1];
        wdExpire = (q.mode == ST_INIT || q.mode == ST_RUN) && (q.wdCnt == WD_LAST);

        // Watchdog runs in Init and Run, halted in Stop
        if (watchdogKick || q.mode == ST_RESET || q.mode == ST_RELEASE) begin
            d.wdCnt = 24'h000000;
        end else if (!inStop) begin
            d.wdCnt = q.wdCnt + 24'h000001;
        end

        if (newReq && !inStop && (q.mode == ST_INIT || q.mode == ST_RUN)) begin
            if (lq.write) begin
                if (lq.addr == OPERATING_MODE_REG0_ADDR) begin
                    d.opMode = lq.data;
                end else if (lq.addr == IRQ_FLAG_ADDR) begin
                    if (lq.data[SUPPLY_FAIL_BIT]) begin
                        d.supplyFail = 1'b0;
                    end
                end else if (lq.addr == IRQ_ENABLE_ADDR) begin
                    d.irqEnable = lq.data;
                end
                d.rdData = 8'h00;
            end else begin
                if (lq.addr == OPERATING_MODE_REG0_ADDR) begin
                    d.rdData = q.opMode;
                end else if (lq.addr == IRQ_FLAG_ADDR) begin
                    d.rdData = {7'h00, q.supplyFail};
                end else if (lq.addr == IRQ_ENABLE_ADDR) begin
                    d.rdData = q.irqEnable;
                end else begin
                    d.rdData = 8'h00;
                end
            end
        end else if (newReq) begin
            d.rdData = 8'h00;
        end
        // Supply warning: a set in the same cycle as a clear wins
        if (!inStop && q.warnPipe[1] && (q.mode == ST_INIT || q.mode == ST_RUN)) begin
            d.supplyFail = 1'b1;
        end

        // Mode sequencing
        case (q.mode)
            ST_RESET: begin
                d.pinDrive = porFail || (q.holdCnt != 16'h0000);
                if (q.holdCnt != 16'h0000) begin
                    d.holdCnt = q.holdCnt - 16'h0001;
                end
                clearRegs = 1'b1;
                if (!porFail && q.holdCnt == 16'h0000 && !d.pinDrive && !extLow
                        && !q.pinDrive) begin
                    d.mode = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                clearRegs = 1'b1;
                if (q.relCnt != 16'h0000) begin
                    d.relCnt = q.relCnt - 16'h0001;
                end else begin
                    d.mode = ST_INIT;
                end
            end
            ST_INIT, ST_RUN: begin
                if (newReq && !lq.write && lq.addr == STOP_ENTRY_TRIGGER_ADDR) begin
                    d.mode      = ST_STOP;
                    d.stopArmed = 1'b0;
                end else if (newReq && lq.write && lq.addr == OPERATING_MODE_REG0_ADDR
                        && lq.data[SOFT_RESET_BIT]) begin
                    d.mode     = ST_RELEASE;
                    d.relCnt   = RESUME_LAST;
                    d.pinDrive = 1'b0;
                    clearRegs  = 1'b1;
                end else if (newReq && lq.write && lq.addr == OPERATING_MODE_REG0_ADDR) begin
                    d.mode = lq.data[RUN_REQUEST_BIT] ? ST_RUN : ST_INIT;
                end
            end
            ST_STOP: begin
                if (q.sselPipe[1]) begin
                    d.stopArmed = 1'b1;
                end
                if (q.stopArmed && !q.sselPipe[1]) begin
                    d.mode = ST_RUN;
                end
            end
            default: begin
                d.mode = ST_RESET;
            end
        endcase

        // Hardware reset sources override everything
        if (q.mode != ST_RESET) begin
            if (porFail) begin
                d.mode     = ST_RESET;
                d.pinDrive = 1'b1;
                d.holdCnt  = 16'h0000;
                d.relCnt   = RESUME_LAST;
                clearRegs  = 1'b1;
            end else if (extActive) begin
                d.mode     = ST_RESET;
                d.pinDrive = 1'b0;
                d.holdCnt  = 16'h0000;
                d.relCnt   = inStop ? WAKE_LAST : RESUME_LAST;
                clearRegs  = 1'b1;
            end else if (wdExpire) begin
                d.mode     = ST_RESET;
                d.pinDrive = 1'b1;
                d.holdCnt  = PULSE_LAST;
                d.relCnt   = RESUME_LAST;
                clearRegs  = 1'b1;
            end
        end else if (porFail) begin
            d.relCnt = RESUME_LAST;
        end

        if (clearRegs || (d.mode == ST_INIT && q.mode != ST_INIT)) begin
            d.opMode[LOW_POWER_CLOCK_BIT] = 1'b0;
        end
        if (clearRegs) begin
            d.opMode     = OPERATING_MODE_REG0_RESET;
            d.irqEnable  = IRQ_ENABLE_RESET;
            d.supplyFail = 1'b0;
        end
        d.opMode[SOFT_RESET_BIT] = 1'b0;

        d.irqN = !(q.supplyFail && q.irqEnable[SUPPLY_FAIL_EN_BIT]);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            q <= CORE_RESET;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign resetPinOut         = 1'b0;
    assign resetPinOe          = q.pinDrive;
    assign irqN                = q.irqN;
    assign modeInit            = (q.mode == ST_INIT);
    assign modeRun             = (q.mode == ST_RUN);
    assign modeStop            = (q.mode == ST_STOP);
    assign processingEnable    = (q.mode == ST_RUN);
    assign lowPowerClockSelect = q.opMode[LOW_POWER_CLOCK_BIT];

endmodule : mode_reset_sequencer

// ==== verif/mode_reset_sequencer_sva.sv ====
`timescale 1ns/1ps
module mode_reset_sequencer_sva #(
    parameter int STOP_WAKE = 20
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Pin and supply
    input wire logic resetPinIn,
    input wire logic resetPinOe,
    input wire logic supplyAboveResetTrip,
    input wire logic supplyAbovePowerOnTrip,
    // Mode status
    input wire logic modeInit,
    input wire logic modeRun,
    input wire logic modeStop,
    input wire logic processingEnable,
    input wire logic lowPowerClockSelect
);
    localparam int WAKE_LO = STOP_WAKE - 8;
    localparam int WAKE_HI = STOP_WAKE + 4;
    logic stopSeen_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Remembers whether the last settled mode was Stop
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stopSeen_q <= 1'b0;
        end else if (modeStop) begin
            stopSeen_q <= 1'b1;
        end else if (modeInit || modeRun) begin
            stopSeen_q <= 1'b0;
        end
    end

    property p_one_mode;
        $onehot0({modeInit, modeRun, modeStop});
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("two modes at once");
    property p_proc_run;
        processingEnable == modeRun;
    endproperty
    a_proc_run: assert property (p_proc_run) else $error("processing outside Run");
    property p_init_lp;
        $rose(modeInit) |-> !lowPowerClockSelect;
    endproperty
    a_init_lp: assert property (p_init_lp) else $error("low power clock in Init");
    property p_supply_pin;
        !supplyAboveResetTrip && !modeStop |-> ##[0:4] resetPinOe;
    endproperty
    a_supply_pin: assert property (p_supply_pin) else $error("pin not driven");
    property p_stop_no_drive;
        modeStop && supplyAbovePowerOnTrip |=> !resetPinOe;
    endproperty
    a_stop_no_drive: assert property (p_stop_no_drive) else $error("reset in Stop");
    property p_wd_pulse;
        $rose(resetPinOe) && supplyAboveResetTrip && supplyAbovePowerOnTrip
            |-> resetPinOe [*4] ##1 !resetPinOe;
    endproperty
    a_wd_pulse: assert property (p_wd_pulse) else $error("bad reset pulse");
    property p_glitch;
        modeRun && $fell(resetPinIn) ##1 !resetPinIn ##1 !resetPinIn ##1 resetPinIn
            |=> modeRun [*6];
    endproperty
    a_glitch: assert property (p_glitch) else $error("short low took effect");
    property p_ext_release;
        $rose(resetPinIn) && !$past(resetPinOe) && !stopSeen_q && !modeInit && !modeRun
            |-> !modeInit [*4] ##[1:6] modeInit;
    endproperty
    a_ext_release: assert property (p_ext_release) else $error("bad resume");
    property p_stop_release;
        $rose(resetPinIn) && !$past(resetPinOe) && stopSeen_q && !modeInit && !modeRun
            |-> !modeInit [*8] ##[WAKE_LO:WAKE_HI] modeInit;
    endproperty
    a_stop_release: assert property (p_stop_release) else $error("bad wake");
endmodule : mode_reset_sequencer_sva

bind mode_reset_sequencer mode_reset_sequencer_sva #(.STOP_WAKE(STOP_WAKE))
    mode_reset_sequencer_sva_inst (
    .clk(clk), .resetn(resetn), .resetPinIn(resetPinIn), .resetPinOe(resetPinOe),
    .supplyAboveResetTrip(supplyAboveResetTrip), .supplyAbovePowerOnTrip(supplyAbovePowerOnTrip),
    .modeInit(modeInit), .modeRun(modeRun), .modeStop(modeStop),
    .processingEnable(processingEnable), .lowPowerClockSelect(lowPowerClockSelect));

// ==== verif/link_master_model.sv ====
`timescale 1ns/1ps
module link_master_model (
    // Link requests
    output logic             linkClk,
    output logic             reqValid,
    output logic             reqWrite,
    output logic [11:0]      reqAddr,
    output logic [7:0]       reqData,
    // Link answers
    input  wire logic        reqReady,
    input  wire logic        rspValid,
    input  wire logic [7:0]  rspData
);
    logic run;

    // Clock stands low between transfers
    initial begin
        run = 1'b1;
        linkClk = 1'b0;
        reqValid = 1'b0;
        reqWrite = 1'b0;
        reqAddr = 12'hA5A;
        reqData = 8'h5A;
        #7;
        forever begin
            #16;
            if (run || linkClk) linkClk = ~linkClk;
        end
    end

    // One byte request, held until taken, then released to inverted values
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        int n;
        run = 1'b1;
        q = 8'hXX;
        @(posedge linkClk);
        reqValid <= 1'b1;
        reqWrite <= wr;
        reqAddr <= a;
        reqData <= d;
        n = 0;
        do begin
            @(posedge linkClk);
            n++;
        end while (reqReady !== 1'b1 && n < 20);
        reqValid <= 1'b0;
        reqWrite <= ~wr;
        reqAddr <= ~a;
        reqData <= ~d;
        n = 0;
        do begin
            @(posedge linkClk);
            n++;
        end while (rspValid !== 1'b1 && n < 20);
        if (rspValid === 1'b1) q = rspData;
        run = 1'b0;
    endtask : xfer
endmodule : link_master_model

// ==== verif/mode_reset_sequencer_tb.sv ====
`timescale 1ns/1ps
module mode_reset_sequencer_tb;
    import mode_reset_pkg::*;
    localparam int WAKE = 20;
    logic        clk, resetn, sselN, extLow, supOk, supPor, supWarn, kick, kickOn, pinSeen;
    logic        linkClk, reqValid, reqWrite, reqReady, rspValid, resetPinIn, resetPinOut;
    logic        resetPinOe, irqN, modeInit, modeRun, modeStop, procEn, lowPwr;
    logic [11:0] reqAddr;
    logic [7:0]  reqData, rspData, rd, expOp;
    int          err_total, n_compared, cyc, seed, i;

    mode_reset_sequencer #(.STOP_WAKE(WAKE), .WD_TIMEOUT(200)) mode_reset_sequencer_inst (
        .clk(clk), .resetn(resetn), .linkClk(linkClk), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData), .reqReady(reqReady),
        .rspValid(rspValid), .rspData(rspData), .sselN(sselN), .resetPinIn(resetPinIn),
        .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .irqN(irqN),
        .supplyAboveResetTrip(supOk), .supplyAbovePowerOnTrip(supPor),
        .supplyBelowWarnLevel(supWarn), .watchdogKick(kick), .modeInit(modeInit),
        .modeRun(modeRun), .modeStop(modeStop), .processingEnable(procEn),
        .lowPowerClockSelect(lowPwr));
    link_master_model link_master_model_inst (
        .linkClk(linkClk), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));

    // Pulled-up reset pin
    assign resetPinIn = ((resetPinOe && !resetPinOut) || extLow) ? 1'b0 : 1'b1;

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) kick <= kickOn && (($random(seed) & 3) == 0);
    always @(posedge clk) if (resetPinOe === 1'b1) pinSeen <= 1'b1;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc_n
    task wr(input logic [11:0] a, input logic [7:0] d);
        link_master_model_inst.xfer(1'b1, a, d, rd);
        cyc_n(4);
    endtask : wr
    task rdchk(input logic [11:0] a, input logic [7:0] e);
        link_master_model_inst.xfer(1'b0, a, 8'h00, rd);
        chk(rd, e);
        cyc_n(2);
    endtask : rdchk
    task modes(input logic [2:0] e);
        chk({5'h00, modeInit, modeRun, modeStop}, {5'h00, e});
    endtask : modes
    task ext_reset(input int n);
        extLow = 1'b1;
        cyc_n(n);
        extLow = 1'b0;
    endtask : ext_reset
    task finish_test();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    initial begin
        {err_total, n_compared, cyc} = 0;
        seed = 32'h44BF5D2D;
        {sselN, supOk, supPor, kickOn, resetn, extLow, supWarn, pinSeen} = 8'hF0;
        cyc_n(16);
        resetn = 1'b1;
        cyc_n(20);
        modes(3'b100);
        chk({irqN, lowPwr}, 8'h02);
        rdchk(OPERATING_MODE_REG0_ADDR, OPERATING_MODE_REG0_RESET);
        rdchk(IRQ_ENABLE_ADDR, IRQ_ENABLE_RESET);
        rdchk(12'h7A5, 8'h00);
        for (i = 0; i < 6; i++) begin
            if (i == 1 || i == 2) rdchk(STOP_ENTRY_TRIGGER_ADDR, 8'h00);
            if (i == 2) ext_reset(10);
            if (i == 2) cyc_n(10);
            if (i == 2) modes(3'b000);
            if (i == 2) cyc_n(30);
            if (i == 2) modes(3'b100);
            if (i == 2) rdchk(OPERATING_MODE_REG0_ADDR, 8'h00);
            if (i == 2) chk(lowPwr, 8'h00);
            if (i == 2) continue;
            if (i == 1) modes(3'b001);
            if (i != 1) begin
                expOp = 8'h01 | 8'($random(seed) & 2);
                wr(OPERATING_MODE_REG0_ADDR, expOp);
                modes(3'b010);
                chk(lowPwr, {7'h00, expOp[LOW_POWER_CLOCK_BIT]});
                rdchk(OPERATING_MODE_REG0_ADDR, expOp);
            end
            if (i == 0) begin
                supWarn = 1'b1;
                cyc_n(6);
                supWarn = 1'b0;
                rdchk(IRQ_FLAG_ADDR, 8'h01);
                chk(irqN, 8'h01);
                wr(IRQ_ENABLE_ADDR, 8'h01);
                chk(irqN, 8'h00);
                wr(IRQ_FLAG_ADDR, 8'h01);
                chk(irqN, 8'h01);
                rdchk(STOP_ENTRY_TRIGGER_ADDR, 8'h00);
                modes(3'b001);
                wr(OPERATING_MODE_REG0_ADDR, 8'h08);
                {kickOn, supWarn} = 2'b01;
                cyc_n(300);
                {kickOn, supWarn} = 2'b10;
                modes(3'b001);
                sselN = 1'b0;
                cyc_n(8);
                sselN = 1'b1;
                cyc_n(4);
                modes(3'b010);
                rdchk(OPERATING_MODE_REG0_ADDR, expOp);
                rdchk(IRQ_ENABLE_ADDR, 8'h01);
                rdchk(IRQ_FLAG_ADDR, 8'h00);
                ext_reset(3);
                cyc_n(10);
                modes(3'b010);
                ext_reset(10);
                cyc_n(14);
                modes(3'b100);
                rdchk(IRQ_ENABLE_ADDR, 8'h00);
            end
            if (i == 1) begin
                supOk = 1'b0;
                cyc_n(10);
                chk({modeStop, resetPinOe}, 8'h02);
                supPor = 1'b0;
                cyc_n(10);
                chk({modeStop, resetPinOe}, 8'h01);
                {supOk, supPor} = 2'b11;
                cyc_n(20);
                modes(3'b100);
                rdchk(OPERATING_MODE_REG0_ADDR, 8'h00);
            end
            if (i == 3) begin
                pinSeen = 1'b0;
                wr(OPERATING_MODE_REG0_ADDR, 8'h08);
                cyc_n(10);
                modes(3'b100);
                chk({pinSeen, lowPwr}, 8'h00);
                rdchk(OPERATING_MODE_REG0_ADDR, 8'h00);
            end
            if (i == 4) begin
                {kickOn, pinSeen} = 2'b00;
                cyc_n(150);
                chk(resetPinOe, 8'h00);
                cyc_n(120);
                chk({pinSeen, modeInit, modeRun}, 8'h06);
                kickOn = 1'b1;
                cyc_n(20);
                modes(3'b100);
                rdchk(IRQ_FLAG_ADDR, 8'h00);
            end
        end
        finish_test();
    end
endmodule : mode_reset_sequencer_tb
